//--- rtl/quad_reg_consts.svh
// Purpose: shared constants for the dual four-bit register block
// Assumes: included by bare name from the store, top and bench files; the package does not include it
// Notes: definitions only
`ifndef QUAD_REG_CONSTS_SVH
`define QUAD_REG_CONSTS_SVH

// bits held by one register group
`define QR_GROUP_BITS 4
// independent register groups in the block
`define QR_GROUP_COUNT 2
// value a group holds after a clear or a reset
`define QR_CLEARED_VALUE 4'h0
// flip-flops each pin passes before any logic reads it
`define QR_SYNC_STAGES 2
// system clock rate in hertz
`define QR_CLK_HZ 40000000

`endif

//--- rtl/quad_reg_pkg.sv
// Purpose: types shared by the dual four-bit register block
// Assumes: nothing
// Notes: constants live in quad_reg_consts.svh
package quad_reg_pkg;

   // build option: drive the stored data or its complement
   typedef enum logic {
      POL_TRUE   = 1'b0,
      POL_INVERT = 1'b1
   } out_polarity_t;

endpackage

//--- rtl/quad_group_store.sv
// Purpose: storage of one four-bit register group
// Assumes: load_en is a one-cycle pulse marking a rising group clock edge
// Notes: clear and data are already synchronised to ref_clk
`include "quad_reg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module quad_group_store #(
   parameter int BITS = `QR_GROUP_BITS
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic load_en,
   input wire logic sync_clear_n,
   input wire logic [BITS-1:0] data,
   output logic [BITS-1:0] stored_q
);

   // all bits load together, each from its own input; nothing moves between edges
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         stored_q <= BITS'(`QR_CLEARED_VALUE);
      end else if (load_en) begin
         if (!sync_clear_n) begin
            stored_q <= BITS'(`QR_CLEARED_VALUE); // see R3
         end else begin
            stored_q <= data; // see R2 see R7
         end
      end
   end

endmodule // quad_group_store

`default_nettype wire

//--- rtl/dual_quad_tristate_dff_register.sv
// Purpose: two independent four-bit edge-triggered registers with three-state outputs
// Assumes: group clocks and all controls are asynchronous pins sampled by ref_clk
// Notes: group clocks must stay well below half the ref_clk rate
//
// Behaviour
// R1: two independent four-bit groups, own controls each
// R2: rising group clock loads data when clear inactive
// R3: low clear at rising edge zeroes group
// R4: high output control floats group outputs
// R5: build option picks true or inverted outputs
// R6: contents hold between rising clock edges
// R7: four bits load in parallel, no shifting
// R8: disabled outputs still allow loading and clearing
`include "quad_reg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_quad_tristate_dff_register
   import quad_reg_pkg::*;
#(
   parameter int BITS = `QR_GROUP_BITS,
   parameter out_polarity_t POLARITY = POL_TRUE
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic group_one_clock,
   input wire logic group_one_sync_clear_n,
   input wire logic group_one_output_disable_n,
   input wire logic [BITS-1:0] group_one_data,
   output logic [BITS-1:0] group_one_q,
   output logic [BITS-1:0] group_one_q_oe,
   input wire logic group_two_clock,
   input wire logic group_two_sync_clear_n,
   input wire logic group_two_output_disable_n,
   input wire logic [BITS-1:0] group_two_data,
   output logic [BITS-1:0] group_two_q,
   output logic [BITS-1:0] group_two_q_oe
);

   localparam int GROUPS = `QR_GROUP_COUNT;

   if (BITS < 1 || BITS > 64) begin : g_bad_width
      $error("BITS must lie between 1 and 64");
   end
   if (GROUPS != 2) begin : g_bad_groups
      $error("the port list serves exactly two groups");
   end

   // pins gathered per group so the same logic serves both
   logic [GROUPS-1:0] clk_pin;
   logic [GROUPS-1:0] clr_pin_n;
   logic [GROUPS-1:0] dis_pin;
   logic [BITS-1:0] data_pin [GROUPS];

   // synchroniser stages: stage one is read only by stage two
   logic [GROUPS-1:0] clk_s1_q;
   logic [GROUPS-1:0] clk_s2_q;
   logic [GROUPS-1:0] clk_prev_q;
   logic [GROUPS-1:0] clr_s1_q;
   logic [GROUPS-1:0] clr_s2_q;
   logic [GROUPS-1:0] dis_s1_q;
   logic [GROUPS-1:0] dis_s2_q;
   logic [BITS-1:0] data_s1_q [GROUPS];
   logic [BITS-1:0] data_s2_q [GROUPS];

   logic [GROUPS-1:0] edge_pulse;
   logic [BITS-1:0] stored [GROUPS];
   logic [BITS-1:0] drive_q [GROUPS];
   logic [BITS-1:0] oe_q [GROUPS];

   assign clk_pin = {group_two_clock, group_one_clock};
   assign clr_pin_n = {group_two_sync_clear_n, group_one_sync_clear_n};
   assign dis_pin = {group_two_output_disable_n, group_one_output_disable_n};
   assign data_pin[0] = group_one_data;
   assign data_pin[1] = group_two_data;

   for (genvar g = 0; g < GROUPS; g++) begin : g_group

      // clock pin: two stages, then one more flop for edge detection
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            // all stages preset high: a clock held high across reset is not an edge,
            // and a pin that is low at release only falls, which never loads
            clk_s1_q[g] <= 1'b1;
            clk_s2_q[g] <= 1'b1;
            clk_prev_q[g] <= 1'b1;
         end else begin
            clk_s1_q[g] <= clk_pin[g];
            clk_s2_q[g] <= clk_s1_q[g];
            clk_prev_q[g] <= clk_s2_q[g];
         end
      end

      // clear and data share the clock's latency so set-up relations survive
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            clr_s1_q[g] <= 1'b1;
            clr_s2_q[g] <= 1'b1;
            data_s1_q[g] <= '0;
            data_s2_q[g] <= '0;
         end else begin
            clr_s1_q[g] <= clr_pin_n[g];
            clr_s2_q[g] <= clr_s1_q[g];
            data_s1_q[g] <= data_pin[g];
            data_s2_q[g] <= data_s1_q[g];
         end
      end

      // output control; reset leaves the bus floating
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            dis_s1_q[g] <= 1'b1;
            dis_s2_q[g] <= 1'b1;
         end else begin
            dis_s1_q[g] <= dis_pin[g];
            dis_s2_q[g] <= dis_s1_q[g];
         end
      end

      // only a low-to-high transition loads; a held clock does nothing
      assign edge_pulse[g] = clk_s2_q[g] & ~clk_prev_q[g]; // see R2 see R6

      // storage ignores output control entirely
      quad_group_store #(
         .BITS(BITS)
      ) u_store (
         .ref_clk(ref_clk),
         .srst(srst),
         .load_en(edge_pulse[g]), // see R1 see R8
         .sync_clear_n(clr_s2_q[g]),
         .data(data_s2_q[g]),
         .stored_q(stored[g])
      );

      // output stage registered so every top output leaves a flip-flop
      always_ff @(posedge ref_clk) begin
         if (srst) begin
            drive_q[g] <= (POLARITY == POL_INVERT) ? ~BITS'(`QR_CLEARED_VALUE)
                                                   : BITS'(`QR_CLEARED_VALUE);
         end else if (POLARITY == POL_INVERT) begin
            drive_q[g] <= ~stored[g]; // see R5
         end else begin
            drive_q[g] <= stored[g]; // see R5
         end
      end

      always_ff @(posedge ref_clk) begin
         if (srst) begin
            oe_q[g] <= '0;
         end else begin
            oe_q[g] <= {BITS{~dis_s2_q[g]}}; // see R4
         end
      end

      // checks, sampled on ref_clk, quiet during reset
      sequence seq_pin_rise;
         $rose(clk_pin[g]) ##1 clk_pin[g] ##1 clk_pin[g];
      endsequence

      sequence seq_load_edge;
         edge_pulse[g] && clr_s2_q[g];
      endsequence

      sequence seq_clear_edge;
         edge_pulse[g] && !clr_s2_q[g];
      endsequence

      chk_pin_edge_seen: assert property ( // see R2
         @(posedge ref_clk) disable iff (srst)
         seq_pin_rise |-> edge_pulse[g])
         else $error("group clock rise not turned into a load pulse");

      chk_parallel_load: assert property ( // see R7
         @(posedge ref_clk) disable iff (srst)
         seq_load_edge |=> stored[g] == $past(data_s2_q[g]))
         else $error("group did not load all data bits at the edge");

      chk_clear_wins: assert property ( // see R3
         @(posedge ref_clk) disable iff (srst)
         seq_clear_edge |=> stored[g] == BITS'(`QR_CLEARED_VALUE) ##1
                            drive_q[g] == ((POLARITY == POL_INVERT)
                                           ? ~BITS'(`QR_CLEARED_VALUE)
                                           : BITS'(`QR_CLEARED_VALUE)))
         else $error("clear at a rising edge did not clear the group");

      chk_hold_between: assert property ( // see R6
         @(posedge ref_clk) disable iff (srst)
         !edge_pulse[g] |=> $stable(stored[g]))
         else $error("stored value changed without a rising edge");

      chk_groups_apart: assert property ( // see R1
         @(posedge ref_clk) disable iff (srst)
         (!edge_pulse[g] && edge_pulse[1-g]) |=> $stable(stored[g]))
         else $error("one group changed on the other group's clock");

      chk_float_output: assert property ( // see R4
         @(posedge ref_clk) disable iff (srst)
         dis_pin[g] [*3] |=> oe_q[g] == '0)
         else $error("outputs driven while output control high");

      chk_drive_output: assert property ( // see R4
         @(posedge ref_clk) disable iff (srst)
         !dis_s2_q[g] |=> oe_q[g] == {BITS{1'b1}})
         else $error("outputs floating while output control low");

      chk_out_polarity: assert property ( // see R5
         @(posedge ref_clk) disable iff (srst)
         ##1 drive_q[g] == ((POLARITY == POL_INVERT) ? ~$past(stored[g])
                                                     : $past(stored[g])))
         else $error("output polarity does not match the build option");

      chk_load_while_off: assert property ( // see R8
         @(posedge ref_clk) disable iff (srst)
         (seq_load_edge and dis_s2_q[g]) |=> stored[g] == $past(data_s2_q[g]))
         else $error("load blocked while outputs disabled");
   end

   // flip-flop outputs to the ports
   always_comb begin
      group_one_q = drive_q[0];
      group_one_q_oe = oe_q[0];
      group_two_q = drive_q[1];
      group_two_q_oe = oe_q[1];
   end

endmodule // dual_quad_tristate_dff_register

`default_nettype wire

//--- dv/shared_bus_model.sv
// Purpose: shared bus seen by one register group
// Assumes: enable high while the group drives a bit
// Notes: a floating bit flips every cycle so a stale value never passes
`timescale 1ns/1ps
`default_nettype none

module shared_bus_model #(
   parameter int BITS = 4
) (
   input wire logic ref_clk,
   input wire logic [BITS-1:0] drive_val,
   input wire logic [BITS-1:0] drive_en,
   output logic [BITS-1:0] bus
);
   logic float_q = 1'b0;

   always_ff @(posedge ref_clk) begin
      float_q <= ~float_q;
   end

   always_comb begin
      for (int i = 0; i < BITS; i++) begin
         bus[i] = drive_en[i] ? drive_val[i] : float_q;
      end
   end
endmodule // shared_bus_model
`default_nettype wire

//--- dv/dual_quad_tristate_dff_register_tb_top.sv
// Purpose: self-checking bench for the dual four-bit register block
// Assumes: both output polarities built side by side on shared inputs
// Notes: waits follow the fixed load and enable latencies of the block
`include "quad_reg_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dual_quad_tristate_dff_register_tb_top import quad_reg_pkg::*;;
   localparam int W = `QR_GROUP_BITS;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic [1:0] gclk = '0;
   logic [1:0] clr_n = '1;
   logic [1:0] dis_n = '1;
   logic [W-1:0] din [2] = '{default: '0};
   logic [W-1:0] q [2][2];
   logic [W-1:0] oe [2][2];
   logic [W-1:0] bus [2];
   int mismatches = 0;
   int comparisons = 0;

   always #12.5 ref_clk = ~ref_clk;

   // index p: 0 true outputs, 1 inverted outputs
   for (genvar p = 0; p < 2; p++) begin : pol
      dual_quad_tristate_dff_register #(.BITS(W), .POLARITY(out_polarity_t'(p)))
         dual_quad_tristate_dff_register_inst (
         .ref_clk(ref_clk), .srst(srst),
         .group_one_clock(gclk[0]), .group_one_sync_clear_n(clr_n[0]),
         .group_one_output_disable_n(dis_n[0]), .group_one_data(din[0]),
         .group_one_q(q[p][0]), .group_one_q_oe(oe[p][0]),
         .group_two_clock(gclk[1]), .group_two_sync_clear_n(clr_n[1]),
         .group_two_output_disable_n(dis_n[1]), .group_two_data(din[1]),
         .group_two_q(q[p][1]), .group_two_q_oe(oe[p][1]));
   end

   for (genvar g = 0; g < 2; g++) begin : grp
      shared_bus_model #(.BITS(W)) shared_bus_model_inst (
         .ref_clk(ref_clk), .drive_val(q[0][g]), .drive_en(oe[0][g]), .bus(bus[g]));
   end

   task automatic check(input string what, input logic [W-1:0] exp, input logic [W-1:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   // one group clock period, data held two cycles either side of the rise
   task automatic load(input int g, input logic [W-1:0] d, input logic c_n);
      din[g] = d;
      clr_n[g] = c_n;
      cycles(2);
      gclk[g] = 1'b1;
      cycles(2);
      gclk[g] = 1'b0;
      cycles(4);
      clr_n[g] = 1'b1;
   endtask

   task automatic expect_group(input int g, input logic [W-1:0] v, input logic en);
      check("true q", v, q[0][g]);
      check("inverted q", ~v, q[1][g]);
      check("true oe", {W{en}}, oe[0][g]);
      check("inverted oe", {W{en}}, oe[1][g]);
      if (en) check("bus", v, bus[g]);
   endtask

   task automatic load_both();
      dis_n = 2'b00;
      load(0, 4'h5, 1'b1);
      load(1, 4'ha, 1'b1);
      expect_group(0, 4'h5, 1'b1);
      expect_group(1, 4'ha, 1'b1);
   endtask

   // clear low without an edge, and data changing under a held-high clock
   task automatic hold_value();
      clr_n[0] = 1'b0;
      din[0] = 4'hc;
      gclk[1] = 1'b1;
      cycles(3);
      din[1] = 4'h3;
      cycles(8);
      expect_group(0, 4'h5, 1'b1);
      expect_group(1, 4'ha, 1'b1);
      gclk[1] = 1'b0;
      clr_n[0] = 1'b1;
      cycles(3);
   endtask

   task automatic clear_group();
      load(0, 4'hf, 1'b0);
      expect_group(0, '0, 1'b1);
      expect_group(1, 4'ha, 1'b1);
   endtask

   task automatic disabled_load();
      dis_n[0] = 1'b1;
      cycles(4);
      expect_group(0, '0, 1'b0);
      expect_group(1, 4'ha, 1'b1);
      load(0, 4'h9, 1'b1);
      dis_n[0] = 1'b0;
      cycles(4);
      expect_group(0, 4'h9, 1'b1);
      dis_n[1] = 1'b1;
      load(1, 4'h6, 1'b0);
      dis_n[1] = 1'b0;
      cycles(4);
      expect_group(1, '0, 1'b1);
   endtask

   // reset in mid-run with a group clock held high: the release must not load
   task automatic reset_held_clock();
      din[0] = 4'h7;
      gclk[0] = 1'b1;
      cycles(6);
      expect_group(0, 4'h7, 1'b1);
      srst = 1'b1;
      cycles(3);
      srst = 1'b0;
      cycles(8);
      expect_group(0, '0, 1'b1);
      expect_group(1, '0, 1'b1);
      gclk[0] = 1'b0;
      cycles(4);
      load(0, 4'h3, 1'b1);
      expect_group(0, 4'h3, 1'b1);
   endtask

   task automatic close_out();
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   initial begin
      cycles(10);
      srst = 1'b0;
      cycles(1);
      expect_group(0, '0, 1'b0);
      expect_group(1, '0, 1'b0);
      load_both();
      hold_value();
      clear_group();
      disabled_load();
      reset_held_clock();
      close_out();
   end

   // the sequence needs about 110 cycles; allow ample margin
   initial begin
      #(25 * 2000);
      mismatches++;
      close_out();
   end
endmodule // dual_quad_tristate_dff_register_tb_top
`default_nettype wire
